// ---- core/ttbc_ds_runner.sv ----
// Downstream engine that runs one buffered transaction with local error retries.
`timescale 1ns/1ps
module ttbc_ds_runner #(
	parameter int EP_W   = ttbc_pkg::EP_W,
	parameter int DATA_W = ttbc_pkg::DATA_W
) (
	input  wire logic              clk_sys,
	input  wire logic              srst,
	input  wire logic              ce,
	input  wire logic              job_valid,
	output logic                   job_ready,
	input  wire logic [EP_W-1:0]   job_ep,
	input  wire logic              job_in,
	input  wire logic [DATA_W-1:0] job_data,
	output logic                   fin_valid,
	output ttbc_pkg::ttbc_hs_t     fin_code,
	output logic [DATA_W-1:0]      fin_data,
	input  wire logic              ds_ready,
	output logic                   ds_start,
	output logic [EP_W-1:0]        ds_ep,
	output logic                   ds_in,
	output logic [DATA_W-1:0]      ds_wdata,
	input  wire logic              ds_done,
	input  wire logic              ds_err,
	input  wire ttbc_pkg::ttbc_hs_t ds_code,
	input  wire logic [DATA_W-1:0] ds_rdata,
	input  wire logic              eof
);

	ttbc_pkg::ttbc_run_t state, next_state;
	logic [1:0]          errcnt, next_errcnt;
	logic [EP_W-1:0]     next_ds_ep;
	logic                next_ds_in;
	logic [DATA_W-1:0]   next_ds_wdata;
	logic                next_fin_valid;
	ttbc_pkg::ttbc_hs_t  next_fin_code;
	logic [DATA_W-1:0]   next_fin_data;
	logic                fail;

	assign job_ready = (state == ttbc_pkg::RUN_IDLE);
	assign ds_start  = ce && (state == ttbc_pkg::RUN_ISSUE) && ds_ready;
	// An end of frame while the transfer is on the wire is handled like a transaction error.
	assign fail      = (ds_done && ds_err) || (eof && !ds_done);

	always_comb begin
		next_state     = state;
		next_errcnt    = errcnt;
		next_ds_ep     = ds_ep;
		next_ds_in     = ds_in;
		next_ds_wdata  = ds_wdata;
		next_fin_valid = 1'b0;
		next_fin_code  = fin_code;
		next_fin_data  = fin_data;
		unique case (state)
			ttbc_pkg::RUN_IDLE: begin
				if (job_valid) begin
					next_ds_ep    = job_ep;
					next_ds_in    = job_in;
					next_ds_wdata = job_data;
					next_errcnt   = ttbc_pkg::ERR_ZERO;
					next_state    = ttbc_pkg::RUN_ISSUE;
				end
			end
			ttbc_pkg::RUN_ISSUE: begin
				if (ds_ready) begin
					next_state = ttbc_pkg::RUN_WAIT;
				end
			end
			ttbc_pkg::RUN_WAIT: begin
				if (ds_done && !ds_err) begin
					next_fin_valid = 1'b1;
					next_fin_code  = ds_code;
					next_fin_data  = ds_rdata;
					next_state     = ttbc_pkg::RUN_IDLE;
				end else if (fail && errcnt == ttbc_pkg::ERR_LAST) begin
					next_fin_valid = 1'b1;
					next_fin_code  = ttbc_pkg::HS_STALL;
					next_fin_data  = '0;
					next_state     = ttbc_pkg::RUN_IDLE;
				end else if (fail) begin
					next_errcnt = errcnt + 2'h1;
					next_state  = ttbc_pkg::RUN_ISSUE;
				end
			end
			default: begin
				next_state = ttbc_pkg::RUN_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state     <= ttbc_pkg::RUN_IDLE;
			errcnt    <= ttbc_pkg::ERR_ZERO;
			ds_ep     <= '0;
			ds_in     <= 1'b0;
			ds_wdata  <= '0;
			fin_valid <= 1'b0;
			fin_code  <= ttbc_pkg::HS_ACK;
			fin_data  <= '0;
		end else if (ce) begin
			state     <= next_state;
			errcnt    <= next_errcnt;
			ds_ep     <= next_ds_ep;
			ds_in     <= next_ds_in;
			ds_wdata  <= next_ds_wdata;
			fin_valid <= next_fin_valid;
			fin_code  <= next_fin_code;
			fin_data  <= next_fin_data;
		end
	end

	default clocking rcb @(posedge clk_sys); endclocking
	default disable iff (srst);

	third_err_a: assert property (ce && state == ttbc_pkg::RUN_WAIT && fail && errcnt == 2'h2
		|=> fin_valid && fin_code == ttbc_pkg::HS_STALL && state == ttbc_pkg::RUN_IDLE)
		else $error("third downstream error did not give stall");
	no_retry_a: assert property (ce && state == ttbc_pkg::RUN_WAIT && ds_done && !ds_err
		|=> fin_valid && fin_code == $past(ds_code) && state == ttbc_pkg::RUN_IDLE)
		else $error("handshake result was retried or altered");
	eof_error_a: assert property (ce && state == ttbc_pkg::RUN_WAIT && eof && !ds_done && errcnt < 2'h2
		|=> state == ttbc_pkg::RUN_ISSUE && errcnt == $past(errcnt) + 2'h1)
		else $error("end of frame not counted as error");
	stall_cover_c: cover property (ce && state == ttbc_pkg::RUN_WAIT && fail && errcnt == 2'h2);

endmodule : ttbc_ds_runner

// ---- core/ttbc_pkg.sv ----
// Constants and types shared by the bulk/control split buffer and its downstream runner.
package ttbc_pkg;

	localparam int EP_W     = 11;
	localparam int DATA_W   = 32;
	localparam int NBUF_DEF = 2;
	localparam int ERR_LIMIT = 3;

	localparam logic [1:0] ERR_LAST = 2'(ERR_LIMIT - 1);
	localparam logic [1:0] ERR_ZERO = 2'h0;

	typedef enum logic [1:0] {
		BUF_FREE  = 2'b00,
		BUF_PEND  = 2'b01,
		BUF_READY = 2'b10,
		BUF_OLD   = 2'b11
	} ttbc_buf_t;

	typedef enum logic [1:0] {
		HS_ACK   = 2'b00,
		HS_NAK   = 2'b01,
		HS_NYET  = 2'b10,
		HS_STALL = 2'b11
	} ttbc_hs_t;

	typedef enum logic {
		SPLIT_START    = 1'b0,
		SPLIT_COMPLETE = 1'b1
	} ttbc_split_t;

	typedef enum logic [1:0] {
		RUN_IDLE  = 2'b00,
		RUN_ISSUE = 2'b01,
		RUN_WAIT  = 2'b10
	} ttbc_run_t;

endpackage : ttbc_pkg

// ---- core/ttbc_split_buffer.sv ----
// Bulk/control split-transaction buffer pool with high-speed answers and downstream scheduling.
`timescale 1ns/1ps
module ttbc_split_buffer #(
	parameter int NBUF   = ttbc_pkg::NBUF_DEF,
	parameter int EP_W   = ttbc_pkg::EP_W,
	parameter int DATA_W = ttbc_pkg::DATA_W
) (
	input  wire logic                 clk_sys,
	input  wire logic                 srst,
	input  wire logic                 ce,
	input  wire logic                 req_valid,
	input  wire ttbc_pkg::ttbc_split_t req_kind,
	input  wire logic [EP_W-1:0]      req_ep,
	input  wire logic                 req_in,
	input  wire logic [DATA_W-1:0]    req_data,
	output logic                      resp_valid,
	output ttbc_pkg::ttbc_hs_t        resp_code,
	output logic [DATA_W-1:0]         resp_data,
	input  wire logic                 clr_valid,
	input  wire logic [EP_W-1:0]      clr_ep,
	input  wire logic                 ds_ready,
	output logic                      ds_start,
	output logic [EP_W-1:0]           ds_ep,
	output logic                      ds_in,
	output logic [DATA_W-1:0]         ds_wdata,
	input  wire logic                 ds_done,
	input  wire logic                 ds_err,
	input  wire ttbc_pkg::ttbc_hs_t   ds_code,
	input  wire logic [DATA_W-1:0]    ds_rdata,
	input  wire logic                 eof
);

	localparam int IDX_W = (NBUF > 1) ? $clog2(NBUF) : 1;

	ttbc_pkg::ttbc_buf_t st[NBUF], next_st[NBUF];
	logic [EP_W-1:0]     ep_tab[NBUF], next_ep_tab[NBUF];
	logic                in_tab[NBUF], next_in_tab[NBUF];
	logic [DATA_W-1:0]   wd_tab[NBUF], next_wd_tab[NBUF];
	ttbc_pkg::ttbc_hs_t  code_tab[NBUF], next_code_tab[NBUF];
	logic [DATA_W-1:0]   rd_tab[NBUF], next_rd_tab[NBUF];

	logic                next_resp_valid;
	ttbc_pkg::ttbc_hs_t  next_resp_code;
	logic [DATA_W-1:0]   next_resp_data;
	logic                run_busy, next_run_busy;
	logic                run_live, next_run_live;
	logic [IDX_W-1:0]    run_idx, next_run_idx;

	logic [NBUF-1:0]     m_free, m_live, m_old, m_pend;
	logic [IDX_W:0]      free_sel, live_sel, old_sel, pend_sel, hit_sel;
	logic [IDX_W-1:0]    hit_idx;
	logic                ss, cs, cs_done;
	ttbc_pkg::ttbc_hs_t  hit_code;
	logic [DATA_W-1:0]   hit_data;
	logic                job_valid, job_ready, job_go;
	logic                fin_valid;
	ttbc_pkg::ttbc_hs_t  fin_code;
	logic [DATA_W-1:0]   fin_data;

	// Lowest buffer whose mask bit is set; the top bit flags that one was found.
	function automatic logic [IDX_W:0] first_set(input logic [NBUF-1:0] m);
		first_set = '0;
		for (int i = NBUF - 1; i >= 0; i--) begin
			if (m[i]) begin
				first_set = {1'b1, IDX_W'(i)};
			end
		end
	endfunction : first_set

	always_comb begin
		for (int i = 0; i < NBUF; i++) begin
			// Only free or old buffers may take a new start-split.
			m_free[i] = (st[i] == ttbc_pkg::BUF_FREE) || (st[i] == ttbc_pkg::BUF_OLD);
			m_live[i] = ((st[i] == ttbc_pkg::BUF_PEND) || (st[i] == ttbc_pkg::BUF_READY)) && (ep_tab[i] == req_ep);
			m_old[i]  = (st[i] == ttbc_pkg::BUF_OLD) && (ep_tab[i] == req_ep);
			m_pend[i] = (st[i] == ttbc_pkg::BUF_PEND);
		end
	end

	assign free_sel  = first_set(m_free);
	assign live_sel  = first_set(m_live);
	assign old_sel   = first_set(m_old);
	assign pend_sel  = first_set(m_pend);
	// A live buffer outranks an old one of the same endpoint.
	assign hit_sel   = live_sel[IDX_W] ? live_sel : old_sel;
	assign hit_idx   = hit_sel[IDX_W-1:0];
	assign hit_code  = code_tab[hit_idx];
	assign hit_data  = rd_tab[hit_idx];
	assign ss        = ce && req_valid && (req_kind == ttbc_pkg::SPLIT_START);
	assign cs        = ce && req_valid && (req_kind == ttbc_pkg::SPLIT_COMPLETE);
	assign cs_done   = cs && hit_sel[IDX_W] && (st[hit_idx] != ttbc_pkg::BUF_PEND);
	assign job_valid = pend_sel[IDX_W] && !run_busy;
	assign job_go    = job_valid && job_ready;

	ttbc_ds_runner #(
		.EP_W   (EP_W),
		.DATA_W (DATA_W)
	) u_runner (
		.clk_sys   (clk_sys),
		.srst      (srst),
		.ce        (ce),
		.job_valid (job_valid),
		.job_ready (job_ready),
		.job_ep    (ep_tab[pend_sel[IDX_W-1:0]]),
		.job_in    (in_tab[pend_sel[IDX_W-1:0]]),
		.job_data  (wd_tab[pend_sel[IDX_W-1:0]]),
		.fin_valid (fin_valid),
		.fin_code  (fin_code),
		.fin_data  (fin_data),
		.ds_ready  (ds_ready),
		.ds_start  (ds_start),
		.ds_ep     (ds_ep),
		.ds_in     (ds_in),
		.ds_wdata  (ds_wdata),
		.ds_done   (ds_done),
		.ds_err    (ds_err),
		.ds_code   (ds_code),
		.ds_rdata  (ds_rdata),
		.eof       (eof)
	);

	always_comb begin
		next_st         = st;
		next_ep_tab     = ep_tab;
		next_in_tab     = in_tab;
		next_wd_tab     = wd_tab;
		next_code_tab   = code_tab;
		next_rd_tab     = rd_tab;
		next_resp_valid = 1'b0;
		next_resp_code  = resp_code;
		next_resp_data  = resp_data;
		next_run_busy   = run_busy;
		next_run_live   = run_live;
		next_run_idx    = run_idx;
		// A result is kept only if its buffer was not cleared while on the wire.
		if (fin_valid) begin
			next_run_busy = 1'b0;
			if (run_live) begin
				next_st[run_idx]       = ttbc_pkg::BUF_READY;
				next_code_tab[run_idx] = fin_code;
				next_rd_tab[run_idx]   = fin_data;
			end
		end
		if (job_go) begin
			next_run_busy = 1'b1;
			next_run_live = 1'b1;
			next_run_idx  = pend_sel[IDX_W-1:0];
		end
		if (ss) begin
			next_resp_valid = 1'b1;
			next_resp_data  = '0;
			if (live_sel[IDX_W]) begin
				next_resp_code = ttbc_pkg::HS_ACK;
			end else if (free_sel[IDX_W]) begin
				next_resp_code                        = ttbc_pkg::HS_ACK;
				next_st[free_sel[IDX_W-1:0]]          = ttbc_pkg::BUF_PEND;
				next_ep_tab[free_sel[IDX_W-1:0]]      = req_ep;
				next_in_tab[free_sel[IDX_W-1:0]]      = req_in;
				next_wd_tab[free_sel[IDX_W-1:0]]      = req_data;
			end else begin
				next_resp_code = ttbc_pkg::HS_NAK;
			end
		end
		if (cs) begin
			next_resp_valid = 1'b1;
			next_resp_data  = '0;
			if (!hit_sel[IDX_W]) begin
				next_resp_code = ttbc_pkg::HS_STALL;
			end else if (st[hit_idx] == ttbc_pkg::BUF_PEND) begin
				next_resp_code = ttbc_pkg::HS_NYET;
			end else begin
				next_resp_code   = hit_code;
				next_resp_data   = hit_data;
				next_st[hit_idx] = ttbc_pkg::BUF_OLD;
			end
		end
		// A clear is applied last so it wins over anything else done this cycle to buffers already holding that endpoint.
		if (clr_valid) begin
			for (int i = 0; i < NBUF; i++) begin
				if (st[i] != ttbc_pkg::BUF_FREE && ep_tab[i] == clr_ep) begin
					next_st[i] = ttbc_pkg::BUF_FREE;
					if (IDX_W'(i) == next_run_idx) begin
						next_run_live = 1'b0;
					end
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			for (int i = 0; i < NBUF; i++) begin
				st[i]       <= ttbc_pkg::BUF_FREE;
				ep_tab[i]   <= '0;
				in_tab[i]   <= 1'b0;
				wd_tab[i]   <= '0;
				code_tab[i] <= ttbc_pkg::HS_ACK;
				rd_tab[i]   <= '0;
			end
			resp_valid <= 1'b0;
			resp_code  <= ttbc_pkg::HS_ACK;
			resp_data  <= '0;
			run_busy   <= 1'b0;
			run_live   <= 1'b0;
			run_idx    <= '0;
		end else if (ce) begin
			st         <= next_st;
			ep_tab     <= next_ep_tab;
			in_tab     <= next_in_tab;
			wd_tab     <= next_wd_tab;
			code_tab   <= next_code_tab;
			rd_tab     <= next_rd_tab;
			resp_valid <= next_resp_valid;
			resp_code  <= next_resp_code;
			resp_data  <= next_resp_data;
			run_busy   <= next_run_busy;
			run_live   <= next_run_live;
			run_idx    <= next_run_idx;
		end
	end

	default clocking bcb @(posedge clk_sys); endclocking
	default disable iff (srst);

	ss_store_a: assert property (ss && !live_sel[IDX_W] && free_sel[IDX_W] && !clr_valid
		|=> resp_valid && resp_code == ttbc_pkg::HS_ACK && st[$past(free_sel[IDX_W-1:0])] == ttbc_pkg::BUF_PEND)
		else $error("stored start-split not acknowledged");
	// Storing must use up exactly one free or old buffer; overwriting a busy one leaves the count unchanged.
	ss_busy_a: assert property (ss && !live_sel[IDX_W] && free_sel[IDX_W] && !clr_valid
		|=> $countones(m_free) == $past($countones(m_free)) - 1)
		else $error("busy buffer chosen for a new start-split");
	ss_nak_a: assert property (ss && !live_sel[IDX_W] && !free_sel[IDX_W]
		|=> resp_valid && resp_code == ttbc_pkg::HS_NAK)
		else $error("full pool did not answer nak");
	ss_dup_a: assert property (ss && live_sel[IDX_W] && !fin_valid
		|=> resp_valid && resp_code == ttbc_pkg::HS_ACK && ep_tab[$past(live_sel[IDX_W-1:0])] == $past(req_ep)
			&& wd_tab[$past(live_sel[IDX_W-1:0])] == $past(wd_tab[live_sel[IDX_W-1:0]]))
		else $error("repeated start-split not acknowledged");
	cs_nyet_a: assert property (cs && hit_sel[IDX_W] && st[hit_idx] == ttbc_pkg::BUF_PEND
		|=> resp_valid && resp_code == ttbc_pkg::HS_NYET)
		else $error("pending complete-split not answered nyet");
	cs_stall_a: assert property (cs && !hit_sel[IDX_W]
		|=> resp_valid && resp_code == ttbc_pkg::HS_STALL)
		else $error("unmatched complete-split not answered stall");
	cs_answer_a: assert property (cs_done
		|=> resp_valid && resp_code == $past(hit_code) && resp_data == $past(hit_data))
		else $error("complete-split answer differs from stored result");
	cs_old_a: assert property (cs_done && !clr_valid
		|=> st[$past(hit_idx)] == ttbc_pkg::BUF_OLD)
		else $error("answered buffer did not become old");
	fin_ready_a: assert property (ce && fin_valid && run_live && !clr_valid
		|=> st[$past(run_idx)] == ttbc_pkg::BUF_READY && code_tab[$past(run_idx)] == $past(fin_code))
		else $error("downstream result not stored");

	for (genvar g = 0; g < NBUF; g++) begin : g_clr
		clr_free_a: assert property (ce && clr_valid && st[g] != ttbc_pkg::BUF_FREE && ep_tab[g] == clr_ep
			|=> st[g] == ttbc_pkg::BUF_FREE)
			else $error("cleared buffer not free");
	end

	ack_cover_c: cover property (ss && !live_sel[IDX_W] && free_sel[IDX_W]);
	nyet_cover_c: cover property (cs && hit_sel[IDX_W] && st[hit_idx] == ttbc_pkg::BUF_PEND);
	answer_cover_c: cover property (cs_done ##1 resp_valid);
	nak_cover_c: cover property (ss && !free_sel[IDX_W] && !live_sel[IDX_W]);

endmodule : ttbc_split_buffer

// ---- tb/tb_top.sv ----
// Self-checking bench for the bulk/control split buffer pool.
`timescale 1ns/1ps
`define CHK(nm, e, s) begin checked++; if ((e) !== (s)) begin bad_count++; $display("mismatch %s exp %0h seen %0h", nm, e, s); end end
module tb_top;
	typedef struct {
		ttbc_pkg::ttbc_split_t k;
		logic [10:0]           ep;
		logic                  di;
		logic [31:0]           d;
		ttbc_pkg::ttbc_hs_t    c;
	} ttbc_row_t;

	logic                  clk_sys, srst, ce, req_valid, req_in, resp_valid, clr_valid, ds_ready, ds_start, ds_in;
	logic                  ds_done, ds_err, eof, in_seen;
	ttbc_pkg::ttbc_split_t req_kind;
	ttbc_pkg::ttbc_hs_t    resp_code, ds_code, hs_v, got_code;
	logic [10:0]           req_ep, clr_ep, ds_ep, ep_seen;
	logic [31:0]           req_data, resp_data, ds_wdata, ds_rdata, rd_v, got_data, wd_seen;
	int                    bad_count, checked, err_budget, dly, starts, dones, s0, d0, i;
	ttbc_row_t             rows [7] = '{
		'{ttbc_pkg::SPLIT_COMPLETE, 11'h005, 1'b0, 32'h0000_0000, ttbc_pkg::HS_STALL},
		'{ttbc_pkg::SPLIT_START,    11'h001, 1'b0, 32'h1234_5678, ttbc_pkg::HS_ACK},
		'{ttbc_pkg::SPLIT_COMPLETE, 11'h001, 1'b0, 32'h0000_0000, ttbc_pkg::HS_NYET},
		'{ttbc_pkg::SPLIT_START,    11'h001, 1'b0, 32'hDEAD_0001, ttbc_pkg::HS_ACK},
		'{ttbc_pkg::SPLIT_START,    11'h002, 1'b1, 32'h0000_0000, ttbc_pkg::HS_ACK},
		'{ttbc_pkg::SPLIT_START,    11'h003, 1'b0, 32'h0000_0003, ttbc_pkg::HS_NAK},
		'{ttbc_pkg::SPLIT_COMPLETE, 11'h003, 1'b0, 32'h0000_0000, ttbc_pkg::HS_STALL}};

	ttbc_split_buffer #(.NBUF(2)) dut (
		.clk_sys(clk_sys), .srst(srst), .ce(ce), .req_valid(req_valid), .req_kind(req_kind), .req_ep(req_ep),
		.req_in(req_in), .req_data(req_data), .resp_valid(resp_valid), .resp_code(resp_code),
		.resp_data(resp_data), .clr_valid(clr_valid), .clr_ep(clr_ep), .ds_ready(ds_ready), .ds_start(ds_start),
		.ds_ep(ds_ep), .ds_in(ds_in), .ds_wdata(ds_wdata), .ds_done(ds_done), .ds_err(ds_err),
		.ds_code(ds_code), .ds_rdata(ds_rdata), .eof(eof));

	ttbc_fs_bus_model bus (
		.clk_sys(clk_sys), .ds_start(ds_start), .ds_in(ds_in), .ds_ep(ds_ep), .ds_wdata(ds_wdata), .eof(eof),
		.err_budget(err_budget), .dly(dly), .hs(hs_v), .rd(rd_v), .ds_done(ds_done), .ds_err(ds_err),
		.ds_code(ds_code), .ds_rdata(ds_rdata), .wd_seen(wd_seen), .ep_seen(ep_seen), .in_seen(in_seen),
		.starts(starts), .dones(dones));

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : give_verdict

	task automatic split(input ttbc_pkg::ttbc_split_t k, input logic [10:0] ep, input logic din, input logic [31:0] d);
		@(posedge clk_sys);
		req_valid <= 1'b1;
		req_kind <= k;
		req_ep <= ep;
		req_in <= din;
		req_data <= d;
		@(posedge clk_sys);
		req_valid <= 1'b0;
		req_data <= ~d;
		#1;
		got_code = resp_code;
		got_data = resp_data;
		`CHK("resp_valid", 1'b1, resp_valid)
	endtask : split

	task automatic wait_dn(input int n);
		for (i = 0; i < 400 && dones - d0 < n; i++) @(posedge clk_sys);
		if (dones - d0 < n) `CHK("done wait", n, dones - d0)
		repeat (3) @(posedge clk_sys);
	endtask : wait_dn

	task automatic job(input logic [10:0] ep, input logic din, input int nerr, input ttbc_pkg::ttbc_hs_t hs,
		input ttbc_pkg::ttbc_hs_t c);
		int n;
		n = (nerr >= 3) ? 3 : nerr + 1;
		s0 = starts;
		d0 = dones;
		err_budget += nerr;
		hs_v = hs;
		rd_v = {21'h00_0000, ep} ^ 32'hC0DE_0000;
		split(ttbc_pkg::SPLIT_START, ep, din, 32'h0000_0BAD);
		`CHK("ss code", ttbc_pkg::HS_ACK, got_code)
		wait_dn(n);
		`CHK("starts", n, starts - s0)
		`CHK("ds_ep", ep, ep_seen)
		`CHK("ds_in", din, in_seen)
		if (!din) `CHK("job wdata", 32'h0000_0BAD, wd_seen)
		split(ttbc_pkg::SPLIT_COMPLETE, ep, din, 32'h0000_0000);
		`CHK("cs code", c, got_code)
		if (din && c == ttbc_pkg::HS_ACK) `CHK("cs data", rd_v, got_data)
	endtask : job

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	initial begin
		repeat (20000) @(posedge clk_sys);
		bad_count++;
		$display("mismatch watchdog exp done seen hang");
		give_verdict();
	end

	initial begin
		srst = 1'b1;
		ce = 1'b1;
		req_valid = 1'b0;
		req_kind = ttbc_pkg::SPLIT_START;
		req_ep = 11'h000;
		req_in = 1'b0;
		req_data = 32'h0000_0000;
		clr_valid = 1'b0;
		clr_ep = 11'h000;
		ds_ready = 1'b0;
		eof = 1'b0;
		hs_v = ttbc_pkg::HS_ACK;
		rd_v = 32'h00C0_FFEE;
		err_budget = 0;
		dly = 4;
		bad_count = 0;
		checked = 0;
		repeat (5) @(posedge clk_sys);
		srst <= 1'b0;
		foreach (rows[j]) begin
			split(rows[j].k, rows[j].ep, rows[j].di, rows[j].d);
			`CHK("row code", rows[j].c, got_code)
		end
		d0 = dones;
		ds_ready <= 1'b1;
		wait_dn(2);
		`CHK("ds_wdata", 32'h1234_5678, wd_seen)
		split(ttbc_pkg::SPLIT_COMPLETE, 11'h001, 1'b0, 32'h0000_0000);
		`CHK("cs ep1", ttbc_pkg::HS_ACK, got_code)
		// Idle cycles stand for other high-speed traffic sent before the retry.
		repeat (4) @(posedge clk_sys);
		split(ttbc_pkg::SPLIT_COMPLETE, 11'h001, 1'b0, 32'h0000_0000);
		`CHK("cs retry", ttbc_pkg::HS_ACK, got_code)
		split(ttbc_pkg::SPLIT_COMPLETE, 11'h002, 1'b1, 32'h0000_0000);
		`CHK("cs in data", 32'h00C0_FFEE, got_data)
		job(11'h006, 1'b1, 2, ttbc_pkg::HS_ACK, ttbc_pkg::HS_ACK);
		job(11'h007, 1'b1, 3, ttbc_pkg::HS_ACK, ttbc_pkg::HS_STALL);
		job(11'h008, 1'b0, 0, ttbc_pkg::HS_NAK, ttbc_pkg::HS_NAK);
		job(11'h004, 1'b0, 0, ttbc_pkg::HS_STALL, ttbc_pkg::HS_STALL);
		hs_v = ttbc_pkg::HS_ACK;
		dly = 12;
		s0 = starts;
		d0 = dones;
		split(ttbc_pkg::SPLIT_START, 11'h009, 1'b0, 32'h0000_0009);
		for (i = 0; i < 50 && starts == s0; i++) @(posedge clk_sys);
		`CHK("eof start", s0 + 1, starts)
		repeat (2) @(posedge clk_sys);
		eof <= 1'b1;
		@(posedge clk_sys);
		eof <= 1'b0;
		wait_dn(1);
		`CHK("eof reissue", 2, starts - s0)
		split(ttbc_pkg::SPLIT_COMPLETE, 11'h009, 1'b0, 32'h0000_0000);
		`CHK("eof result", ttbc_pkg::HS_ACK, got_code)
		dly = 4;
		d0 = dones;
		split(ttbc_pkg::SPLIT_START, 11'h00A, 1'b0, 32'h0000_000A);
		split(ttbc_pkg::SPLIT_START, 11'h00B, 1'b0, 32'h0000_000B);
		wait_dn(2);
		ds_ready <= 1'b0;
		split(ttbc_pkg::SPLIT_START, 11'h00C, 1'b0, 32'h0000_000C);
		`CHK("ready busy", ttbc_pkg::HS_NAK, got_code)
		@(posedge clk_sys);
		clr_valid <= 1'b1;
		clr_ep <= 11'h00A;
		@(posedge clk_sys);
		clr_valid <= 1'b0;
		clr_ep <= 11'h7F5;
		split(ttbc_pkg::SPLIT_START, 11'h00C, 1'b0, 32'h0000_000C);
		`CHK("after clear", ttbc_pkg::HS_ACK, got_code)
		split(ttbc_pkg::SPLIT_COMPLETE, 11'h00A, 1'b0, 32'h0000_0000);
		`CHK("cleared cs", ttbc_pkg::HS_STALL, got_code)
		split(ttbc_pkg::SPLIT_COMPLETE, 11'h00B, 1'b0, 32'h0000_0000);
		`CHK("kept cs", ttbc_pkg::HS_ACK, got_code)
		split(ttbc_pkg::SPLIT_COMPLETE, 11'h00D, 1'b0, 32'h0000_0000);
		`CHK("unmatched cs", ttbc_pkg::HS_STALL, got_code)
		// A request presented with reset must not be answered, and the last code must go back to its reset value.
		@(posedge clk_sys);
		srst <= 1'b1;
		req_valid <= 1'b1;
		req_kind <= ttbc_pkg::SPLIT_COMPLETE;
		req_ep <= 11'h00D;
		@(posedge clk_sys);
		req_valid <= 1'b0;
		@(posedge clk_sys);
		#1;
		`CHK("reset resp_valid", 1'b0, resp_valid)
		`CHK("reset resp_code", ttbc_pkg::HS_ACK, resp_code)
		@(posedge clk_sys);
		srst <= 1'b0;
		split(ttbc_pkg::SPLIT_COMPLETE, 11'h00C, 1'b0, 32'h0000_0000);
		`CHK("reset frees", ttbc_pkg::HS_STALL, got_code)
		// With the clock enable low a start-split must be neither answered nor stored.
		@(posedge clk_sys);
		ce <= 1'b0;
		req_valid <= 1'b1;
		req_kind <= ttbc_pkg::SPLIT_START;
		req_ep <= 11'h00E;
		req_data <= 32'h0000_000E;
		repeat (3) @(posedge clk_sys);
		#1;
		`CHK("frozen resp_valid", 1'b0, resp_valid)
		@(posedge clk_sys);
		req_valid <= 1'b0;
		ce <= 1'b1;
		split(ttbc_pkg::SPLIT_COMPLETE, 11'h00E, 1'b0, 32'h0000_0000);
		`CHK("frozen ss", ttbc_pkg::HS_STALL, got_code)
		give_verdict();
	end
endmodule : tb_top

// ---- tb/ttbc_fs_bus_model.sv ----
// Behavioural downstream bus that answers each issued transaction after a delay unless an end of frame cuts it.
`timescale 1ns/1ps
module ttbc_fs_bus_model (
	input  wire logic               clk_sys,
	input  wire logic               ds_start,
	input  wire logic               ds_in,
	input  wire logic [10:0]        ds_ep,
	input  wire logic [31:0]        ds_wdata,
	input  wire logic               eof,
	input  int                      err_budget,
	input  int                      dly,
	input  ttbc_pkg::ttbc_hs_t      hs,
	input  wire logic [31:0]        rd,
	output logic                    ds_done,
	output logic                    ds_err,
	output ttbc_pkg::ttbc_hs_t      ds_code,
	output logic [31:0]             ds_rdata,
	output logic [31:0]             wd_seen,
	output logic [10:0]             ep_seen,
	output logic                    in_seen,
	output int                      starts,
	output int                      dones
);
	int   errs_used;
	int   k;
	logic cut;

	// An end of frame abandons the wire transaction, so no completion follows it.
	initial begin
		ds_done = 1'b0;
		ds_err = 1'b0;
		ds_code = ttbc_pkg::HS_NYET;
		ds_rdata = 32'h5A5A_5A5A;
		wd_seen = 32'h0000_0000;
		ep_seen = 11'h000;
		in_seen = 1'b0;
		starts = 0;
		dones = 0;
		errs_used = 0;
		forever begin
			@(negedge clk_sys);
			if (ds_start === 1'b1) begin
				starts++;
				if (ds_in === 1'b0) wd_seen = ds_wdata;
				ep_seen = ds_ep;
				in_seen = ds_in;
				cut = 1'b0;
				for (k = 0; k < dly && !cut; k++) begin
					@(negedge clk_sys);
					cut = (eof === 1'b1);
				end
				if (!cut) begin
					@(posedge clk_sys);
					ds_done <= 1'b1;
					ds_err <= (errs_used < err_budget);
					ds_code <= hs;
					ds_rdata <= rd;
					if (errs_used < err_budget) errs_used++;
					@(posedge clk_sys);
					dones++;
					ds_done <= 1'b0;
					ds_err <= ~ds_err;
					ds_code <= ttbc_pkg::HS_NYET;
					ds_rdata <= ~rd;
				end
			end
		end
	end
endmodule : ttbc_fs_bus_model
